// ==== afe_pkg.sv ====
package afe_pkg;
	// serial control frame layout
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned DATA_W     = 8;
	localparam logic [4:0]  ADDR_DONE  = 5'h08; // rw flag and address shifted in
	localparam logic [4:0]  FRAME_DONE = 5'h10;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_FRONT_END = 7'h00;
	localparam logic [ADDR_W-1:0] REG_LOOP_TEST = 7'h01;
	localparam logic [ADDR_W-1:0] REG_REVISION  = 7'h06;

	// reset values
	localparam logic [DATA_W-1:0] FRONT_END_RESET = 8'h08;
	localparam logic [DATA_W-1:0] LOOP_TEST_RESET = 8'h00;

	// front_end_control fields
	localparam int unsigned FE_ENABLE_BIT  = 7;
	localparam int unsigned FE_UNUSED_BIT  = 6;
	localparam int unsigned FE_BOOST_HI    = 5;
	localparam int unsigned FE_BOOST_LO    = 4;
	localparam int unsigned FE_TX_DISABLE  = 3;
	localparam int unsigned FE_GAIN_LSB    = 1;
	localparam int unsigned FE_GAIN_PLUS20 = 0;

	// loop_test_control fields
	localparam int unsigned LT_TEST_MODE  = 7;
	localparam int unsigned LT_DIG_LOOP   = 6;
	localparam int unsigned LT_LOCAL_LOOP = 5;
	localparam int unsigned LT_REMOTE_LP  = 4;
	localparam int unsigned LT_CLK_OUT    = 3;
	localparam int unsigned LT_BIAS_PULL  = 2;
	localparam int unsigned LT_CTL_POS    = 1;
	localparam int unsigned LT_HW_SYNC    = 0;

	// revision register: level in bits 7..4, rest reads zero
	localparam int unsigned REV_LSB = 4;

	// receive gain steps in dB
	localparam logic [4:0] GAIN_DB_00   = 5'h06;
	localparam logic [4:0] GAIN_DB_01   = 5'h09;
	localparam logic [4:0] GAIN_DB_10   = 5'h0c;
	localparam logic [4:0] GAIN_DB_11   = 5'h00;
	localparam logic [5:0] GAIN_DB_BOOST = 6'h14;

	typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_t;
endpackage

// ==== afe_serial_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
module afe_serial_ctl
	import afe_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire logic                      reset,
	input  wire logic                      ce,
	input  wire logic                      sclk_pin,
	input  wire logic                      frame_sync_pin_n,
	input  wire logic                      serial_data_in,
	input  wire logic [afe_pkg::DATA_W-1:0] rd_data,
	output logic      [afe_pkg::ADDR_W-1:0] rd_addr,
	output logic                           wr_stb,
	output logic      [afe_pkg::ADDR_W-1:0] wr_addr,
	output logic      [afe_pkg::DATA_W-1:0] wr_data,
	output logic                           serial_data_out,
	output logic                           serial_data_oe
);
	import afe_pkg::*;

	logic [2:0]            pin_raw;
	logic [2:0]            sync1_q;
	logic [2:0]            sync2_q;
	logic                  sclk_old_q;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  frame_on;
	link_state_t           state_q, state_d;
	logic [4:0]            cnt_q, cnt_d;
	logic [FRAME_BITS-1:0] shin_q, shin_d;
	logic [DATA_W-1:0]     shout_q, shout_d;
	logic                  sdout_q, sdout_d;
	logic                  oe_q, oe_d;
	logic                  stb_q, stb_d;
	logic [ADDR_W-1:0]     waddr_q, waddr_d;
	logic [DATA_W-1:0]     wdata_q, wdata_d;

	// idle pin levels: sclk high, frame sync high, data low
	localparam logic [2:0] PIN_IDLE = 3'b110;

	assign pin_raw = {sclk_pin, frame_sync_pin_n, serial_data_in};

	// pins from the host domain pass two flops before use;
	// reset to idle levels so no false frame or edge follows reset
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					sync1_q[g] <= PIN_IDLE[g];
					sync2_q[g] <= PIN_IDLE[g];
				end else if (ce) begin
					sync1_q[g] <= pin_raw[g];
					sync2_q[g] <= sync1_q[g];
				end
			end
		end
	endgenerate

	// edge finder reads only the second stage
	assign sclk_rise = sync2_q[2] & ~sclk_old_q;
	assign sclk_fall = ~sync2_q[2] & sclk_old_q;
	assign frame_on  = ~sync2_q[1];

	// frame shifter; runs regardless of the front-end enable
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		shin_d  = shin_q;
		shout_d = shout_q;
		sdout_d = sdout_q;
		oe_d    = oe_q;
		stb_d   = 1'b0;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		case (state_q)
			LINK_IDLE: begin
				oe_d = 1'b0;
				// a finished frame waits for frame sync to go away
				if (!frame_on) begin
					cnt_d = 5'h00;
				end else if (cnt_q != FRAME_DONE) begin
					state_d = LINK_SHIFT;
				end
			end
			LINK_SHIFT: begin
				if (!frame_on && cnt_q != FRAME_DONE) begin
					// frame cut short: drop it, no write
					state_d = LINK_IDLE;
					oe_d    = 1'b0;
					cnt_d   = 5'h00;
				end else if (sclk_rise) begin
					shin_d = {shin_q[FRAME_BITS-2:0], sync2_q[0]};
					cnt_d  = cnt_q + 5'h01;
					if (cnt_q == FRAME_DONE - 5'h01) begin
						stb_d   = ~shin_q[FRAME_BITS-2];
						waddr_d = shin_q[FRAME_BITS-3:DATA_W-1];
						wdata_d = shin_d[DATA_W-1:0];
						state_d = LINK_IDLE;
					end
				end else if (sclk_fall && shin_q[DATA_W-1] && cnt_q == ADDR_DONE) begin
					sdout_d = rd_data[DATA_W-1];
					shout_d = {rd_data[DATA_W-2:0], 1'b0};
					oe_d    = 1'b1;
				end else if (sclk_fall && oe_q) begin
					sdout_d = shout_q[DATA_W-1];
					shout_d = {shout_q[DATA_W-2:0], 1'b0};
				end
			end
			default: begin
				state_d = LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclk_old_q <= 1'b1;
			state_q    <= LINK_IDLE;
			cnt_q      <= 5'h00;
			shin_q     <= 16'h0000;
			shout_q    <= 8'h00;
			sdout_q    <= 1'b0;
			oe_q       <= 1'b0;
			stb_q      <= 1'b0;
			waddr_q    <= 7'h00;
			wdata_q    <= 8'h00;
		end else if (ce) begin
			sclk_old_q <= sync2_q[2];
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			shin_q     <= shin_d;
			shout_q    <= shout_d;
			sdout_q    <= sdout_d;
			oe_q       <= oe_d;
			stb_q      <= stb_d;
			waddr_q    <= waddr_d;
			wdata_q    <= wdata_d;
		end
	end

	assign rd_addr         = shin_q[ADDR_W-1:0];
	assign wr_stb          = stb_q;
	assign wr_addr         = waddr_q;
	assign wr_data         = wdata_q;
	assign serial_data_out = sdout_q;
	assign serial_data_oe  = oe_q;
endmodule // afe_serial_ctl
`default_nettype wire

// ==== afe_control_registers.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - front_end_control sits at 0x00 and resets to 0x08.
// - front_end_enable low stops filter and analog clocks.
// - serial port stays clocked so registers remain accessible when disabled.
// - gain decode: 00=6 dB, 01=9 dB, 10=12 dB, 11=0 dB.
// - rx_gain_plus20 set adds 20 dB in the receive front end.
// - loop_test_control sits at 0x01 and resets to 0x00.
// - test_mode_enable set enables the test modes.
// - digital_loopback routes transmit bit stream into receive filters.
// - local_analog_loopback feeds transmitter outputs into receiver input.
// - remote_analog_loopback feeds receiver bit stream into transmitter input.
// - clock output pin driven when clock_out_enable, else tri-stated.
// - rx_bias_pull set applies DC bias to receive inputs.
// - control_frame_position picks quarter or half point for control frames.
// - hardware sync: bit 0 is sample data, control frame every time.
// - software sync: bit 0 requests a control frame.
// - read-only revision at 0x06, level in bits 7..4.
module afe_control_registers
	import afe_pkg::*;
#(
	parameter logic [3:0] REVISION_LEVEL = 4'h1 // arbitrary value
)(
	input  wire logic      clk_sys,
	input  wire logic      reset,
	input  wire logic      ce,
	input  wire logic      sclk_pin,
	input  wire logic      frame_sync_pin_n,
	input  wire logic      serial_data_in,
	output logic           serial_data_out,
	output logic           serial_data_oe,
	input  wire logic      data_frame_done,
	input  wire logic      data_frame_bit0,
	output logic           control_frame_request,
	output logic           control_frame_quarter,
	output logic           tx_bit0_is_sample,
	output logic           filter_clk_en,
	output logic           analog_clk_en,
	output logic           tx_boost_hi,
	output logic           tx_boost_lo,
	output logic           tx_pin_oe,
	output logic [5:0]     rx_gain_db,
	output logic           test_mode_enable,
	output logic           digital_loopback,
	output logic           local_analog_loopback,
	output logic           remote_analog_loopback,
	output logic           rx_bias_pull,
	output logic           clock_output_pin_o,
	output logic           clock_output_pin_oe
);
	import afe_pkg::*;

	logic [DATA_W-1:0] fe_q, fe_d;
	logic [DATA_W-1:0] lt_q, lt_d;
	logic              toggle_q, toggle_d;
	logic              req_q, req_d;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic              wr_stb;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;

	// register map read decode; unmapped offsets read zero
	function automatic logic [DATA_W-1:0] reg_read(
		input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] fe,
		input logic [DATA_W-1:0] lt
	);
		logic [DATA_W-1:0] r;
		r = 8'h00;
		case (a)
			REG_FRONT_END: r = fe;
			REG_LOOP_TEST: r = lt;
			REG_REVISION:  r = {REVISION_LEVEL, 4'h0};
			default:       r = 8'h00;
		endcase
		return r;
	endfunction

	// receive gain step table
	function automatic logic [4:0] gain_step(input logic [1:0] sel);
		logic [4:0] g;
		g = GAIN_DB_11;
		case (sel)
			2'b00:   g = GAIN_DB_00;
			2'b01:   g = GAIN_DB_01;
			2'b10:   g = GAIN_DB_10;
			default: g = GAIN_DB_11;
		endcase
		return g;
	endfunction

	afe_serial_ctl u_link (
		.clk_sys          (clk_sys),
		.reset            (reset),
		.ce               (ce),
		.sclk_pin         (sclk_pin),
		.frame_sync_pin_n (frame_sync_pin_n),
		.serial_data_in   (serial_data_in),
		.rd_data          (rd_data),
		.rd_addr          (rd_addr),
		.wr_stb           (wr_stb),
		.wr_addr          (wr_addr),
		.wr_data          (wr_data),
		.serial_data_out  (serial_data_out),
		.serial_data_oe   (serial_data_oe)
	);

	assign rd_data = reg_read(rd_addr, fe_q, lt_q);

	// register writes; revision writes are ignored
	always_comb begin
		fe_d     = fe_q;
		lt_d     = lt_q;
		toggle_d = toggle_q;
		req_d    = 1'b0;
		if (wr_stb && wr_addr == REG_FRONT_END) begin
			fe_d = wr_data;
			fe_d[FE_UNUSED_BIT] = 1'b0;
		end
		if (wr_stb && wr_addr == REG_LOOP_TEST) begin
			lt_d = wr_data;
		end
		// test clock divider idles low while disabled
		toggle_d = lt_q[LT_CLK_OUT] ? ~toggle_q : 1'b0;
		// control frame after each data frame, or on request bit
		if (data_frame_done) begin
			req_d = lt_q[LT_HW_SYNC] | data_frame_bit0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fe_q     <= FRONT_END_RESET;
			lt_q     <= LOOP_TEST_RESET;
			toggle_q <= 1'b0;
			req_q    <= 1'b0;
		end else if (ce) begin
			fe_q     <= fe_d;
			lt_q     <= lt_d;
			toggle_q <= toggle_d;
			req_q    <= req_d;
		end
	end

	// clock gating only reaches filters and analog, never the link
	assign filter_clk_en = fe_q[FE_ENABLE_BIT];
	assign analog_clk_en = fe_q[FE_ENABLE_BIT];
	assign tx_boost_hi   = fe_q[FE_BOOST_HI];
	assign tx_boost_lo   = fe_q[FE_BOOST_LO];
	assign tx_pin_oe     = ~fe_q[FE_TX_DISABLE];
	assign rx_gain_db = {1'b0, gain_step(fe_q[FE_GAIN_LSB+:2])}
		+ (fe_q[FE_GAIN_PLUS20] ? GAIN_DB_BOOST : 6'h00);

	// loop modes; host must limit level in local loop
	assign test_mode_enable       = lt_q[LT_TEST_MODE];
	assign digital_loopback       = lt_q[LT_DIG_LOOP];
	assign local_analog_loopback  = lt_q[LT_LOCAL_LOOP];
	assign remote_analog_loopback = lt_q[LT_REMOTE_LP];
	assign rx_bias_pull           = lt_q[LT_BIAS_PULL];
	assign control_frame_quarter  = lt_q[LT_CTL_POS];
	assign tx_bit0_is_sample      = lt_q[LT_HW_SYNC];
	assign control_frame_request  = req_q;
	assign clock_output_pin_o     = toggle_q;
	assign clock_output_pin_oe    = lt_q[LT_CLK_OUT];

	// checks on the register bank
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_front_reset: assert property ($past(reset) |-> fe_q == 8'h08 && !tx_pin_oe)
		else $error("front end control not at reset value");
	a_filter_gate: assert property (ce && wr_stb && wr_addr == REG_FRONT_END
		|=> filter_clk_en == $past(wr_data[7]))
		else $error("filter clock enable does not follow write");
	a_gain_table: assert property (fe_q[2:0] == 3'b110 |-> rx_gain_db == 6'h00)
		else $error("gain 11 not 0 dB");
	a_gain_boost: assert property (fe_q[2:0] == 3'b011 |-> rx_gain_db == 6'h1d)
		else $error("gain boost 9 plus 20 wrong");
	a_loop_reset: assert property ($past(reset)
		|-> !digital_loopback && !local_analog_loopback && !clock_output_pin_oe)
		else $error("loop control not cleared by reset");
	a_dig_loop: assert property (ce && wr_stb && wr_addr == REG_LOOP_TEST
		|=> digital_loopback == $past(wr_data[6])
		&& remote_analog_loopback == $past(wr_data[4]))
		else $error("loop bits do not follow write");
	a_clk_tristate: assert property (ce && !lt_q[3] |=> !clock_output_pin_o)
		else $error("clock out toggles while disabled");
	a_ctl_request: assert property (ce && data_frame_done && !lt_q[0]
		&& !data_frame_bit0 |=> !control_frame_request)
		else $error("control frame without request");
	a_ctl_hw: assert property (ce && data_frame_done && lt_q[0]
		|=> control_frame_request)
		else $error("no control frame in hardware sync");
	a_rev_read: assert property (rd_addr == REG_REVISION
		|-> rd_data == {REVISION_LEVEL, 4'h0})
		else $error("revision read wrong");

	c_write_front: cover property (wr_stb && wr_addr == REG_FRONT_END);
	c_write_loop: cover property (wr_stb && wr_addr == REG_LOOP_TEST);
	c_read_out: cover property (serial_data_oe ##1 !serial_data_oe);
	c_ctl_req: cover property (control_frame_request);
endmodule // afe_control_registers
`default_nettype wire

// ==== host_port.sv ====
`timescale 1ns/100ps
`default_nettype none
// host side of the serial link; sclk idles high between frames
module host_port (
	input  wire logic clk_sys,
	output logic      sclk_pin,
	output logic      frame_sync_pin_n,
	output logic      serial_data_in,
	input  wire logic serial_data_out,
	input  wire logic serial_data_oe
);
	initial begin
		sclk_pin = 1'b1;
		frame_sync_pin_n = 1'b1;
		serial_data_in = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// one frame msb first; nbits below 16 aborts it mid-frame
	task automatic xfer(input logic rw, input logic [6:0] addr,
		input logic [7:0] wdata, input int nbits,
		output logic [7:0] rdata);
		logic [15:0] word;
		word = {rw, addr, wdata};
		rdata = 8'h00;
		@(posedge clk_sys);
		frame_sync_pin_n <= 1'b0;
		idle(4);
		for (int i = 15; i >= 16 - nbits; i--) begin
			sclk_pin <= 1'b0;
			// read phase: host line toggles so no stale level lingers
			serial_data_in <= (rw && i < 8) ? ~serial_data_in : word[i];
			idle(4);
			sclk_pin <= 1'b1;
			// sampled at our rising edge, half a period after device fall
			if (i < 8) rdata[i] = serial_data_out & serial_data_oe;
			idle(4);
		end
		frame_sync_pin_n <= 1'b1;
		serial_data_in <= ~serial_data_in;
		idle(6); // gap well over the two-cycle minimum
	endtask
endmodule // host_port
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import afe_pkg::*;
	typedef struct {
		logic [6:0] a;
		logic [7:0] d;
		logic [7:0] rb;
		logic [5:0] g;
	} row_t;
	logic       clk_sys = 1'b0;
	logic       reset   = 1'b1;
	logic       ce      = 1'b1;
	logic       done    = 1'b0;
	logic       bit0    = 1'b0;
	logic       sclk, sync_n, sdi, sdo, sdo_oe, req, quarter, hw;
	logic       fclk, aclk, bhi, blo, txoe, tm, dl, ll, rl, bias;
	logic       cko, cko_oe;
	logic [5:0] gain;
	logic [7:0] rd;
	int         num_errors = 0;
	int         num_checks = 0;
	// reg1 rows first so they land while the front end is disabled;
	// local loop is set with no transmit codes in flight
	row_t rows [8] = '{
		'{7'h01, 8'ha5, 8'ha5, 6'h06}, '{7'h01, 8'h5a, 8'h5a, 6'h06},
		'{7'h00, 8'h88, 8'h88, 6'h06}, '{7'h00, 8'hf3, 8'hb3, 6'h1d},
		'{7'h00, 8'h35, 8'h35, 6'h20}, '{7'h00, 8'h06, 8'h06, 6'h00},
		'{7'h00, 8'h01, 8'h01, 6'h1a}, '{7'h02, 8'h5c, 8'h00, 6'h1a}};

	// revision value is arbitrary
	afe_control_registers #(.REVISION_LEVEL(4'h9)) dut (
		.clk_sys(clk_sys), .reset(reset), .ce(ce), .sclk_pin(sclk),
		.frame_sync_pin_n(sync_n), .serial_data_in(sdi),
		.serial_data_out(sdo), .serial_data_oe(sdo_oe),
		.data_frame_done(done), .data_frame_bit0(bit0),
		.control_frame_request(req), .control_frame_quarter(quarter),
		.tx_bit0_is_sample(hw), .filter_clk_en(fclk),
		.analog_clk_en(aclk), .tx_boost_hi(bhi), .tx_boost_lo(blo),
		.tx_pin_oe(txoe), .rx_gain_db(gain), .test_mode_enable(tm),
		.digital_loopback(dl), .local_analog_loopback(ll),
		.remote_analog_loopback(rl), .rx_bias_pull(bias),
		.clock_output_pin_o(cko), .clock_output_pin_oe(cko_oe));

	host_port host (
		.clk_sys(clk_sys), .sclk_pin(sclk), .frame_sync_pin_n(sync_n),
		.serial_data_in(sdi), .serial_data_out(sdo),
		.serial_data_oe(sdo_oe));

	always #2 clk_sys = ~clk_sys;

	task automatic check(input string what, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, d, 16, rd);
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
		host.xfer(1'b1, a, 8'h00, 16, rd);
		check("readback", rd, exp);
	endtask

	// data frame end pulse; request is due the following cycle only
	task automatic req_chk(input logic b, input logic exp);
		@(posedge clk_sys);
		done <= 1'b1;
		bit0 <= b;
		@(posedge clk_sys);
		done <= 1'b0;
		#1;
		check("request", {7'h00, req}, {7'h00, exp});
		@(posedge clk_sys);
		#1;
		check("request end", {7'h00, req}, 8'h00);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog so a stuck frame cannot hang the run
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		end_sim();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		check("reset levels", {fclk, txoe, cko_oe, req, 4'h0}, 8'h00);
		check("reset gain", {2'b00, gain}, 8'h06);
		check("reset oe", {aclk, sdo_oe, 6'h00}, 8'h00);
		rdchk(7'h00, 8'h08);
		rdchk(7'h01, 8'h00);
		$display("test reset done");

		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].rb);
			if (rows[i].a == 7'h00) begin
				check("fe levels", {fclk, aclk, bhi, blo, txoe, 3'h0},
					{rows[i].d[7], rows[i].d[7], rows[i].d[5:4],
					~rows[i].d[3], 3'h0});
				check("gain", {2'b00, gain}, {2'b00, rows[i].g});
			end else if (rows[i].a == 7'h01) begin
				check("lt levels", {tm, dl, ll, rl, cko_oe, bias,
					quarter, hw}, rows[i].d);
			end
		end
		$display("test table done");

		rdchk(7'h06, 8'h90);
		host.xfer(1'b0, 7'h00, 8'hff, 12, rd);
		rdchk(7'h00, 8'h01);
		ce <= 1'b0;
		wr(7'h00, 8'h80);
		ce <= 1'b1;
		rdchk(7'h00, 8'h01);
		$display("test refusals done");

		req_chk(1'b0, 1'b0);
		req_chk(1'b1, 1'b1);
		wr(7'h01, 8'h5b);
		req_chk(1'b0, 1'b1);
		$display("test requests done");

		@(posedge clk_sys);
		#1;
		rd[0] = cko;
		@(posedge clk_sys);
		#1;
		check("clock out", {7'h00, cko}, {7'h00, ~rd[0]});
		check("clock out oe", {7'h00, cko_oe}, 8'h01);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		check("reset again", {cko_oe, hw, fclk, 5'h00}, 8'h00);
		rdchk(7'h00, 8'h08);
		$display("test clock out and second reset done");
		end_sim();
	end
endmodule // testbench
`default_nettype wire
